// ### hdl/serial_clock_divider.sv
`timescale 1ns/1ps

// ------------------------------------------------------------------
// master clock divider: one tick per half period of pclk / 2^(cks+1)
// ------------------------------------------------------------------
module serial_clock_divider
  import serial_port_pkg::*;
#(
  parameter int CNT_W = 7
) (
  // clock and reset
  input  wire logic   pclk,
  input  wire logic   presetn,
  // link to the port logic
  shift_link_if.gen   link
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             tick;
  } div_state_t;

  div_state_t s_ff;
  div_state_t nxt_s;

  // half period of 2^cks pclk cycles; counter restarts whenever the
  // engine stops so the first edge of a frame is always a full half
  always_comb begin
    nxt_s      = s_ff;
    nxt_s.tick = 1'b0;
    if (!link.run) begin
      nxt_s.cnt = '0;
    end else if (nxt_s.cnt == CNT_W'((1 << link.cks) - 1)) begin
      nxt_s.cnt  = '0;
      nxt_s.tick = 1'b1;
    end else begin
      nxt_s.cnt = s_ff.cnt + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign link.half_tick = s_ff.tick;

endmodule // serial_clock_divider

// ### hdl/serial_port_pkg.sv
package serial_port_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_PORT1_DIRECTION  = 16'hFF21;
  localparam logic [15:0] IDX_SERIAL_MODE      = 16'hFF80;
  localparam logic [15:0] IDX_CLOCK_SELECT     = 16'hFF81;
  localparam logic [15:0] IDX_TRANSMIT_BUFFER  = 16'hFF82;
  localparam logic [15:0] IDX_SHIFT_REGISTER   = 16'hFF83;
  localparam logic [15:0] IDX_PORT1_LATCH      = 16'hFF01;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int MODE_PORT_ENABLE      = 7;
  localparam int MODE_TXRX_SELECT      = 6;
  localparam int MODE_BIT_ORDER        = 4;
  localparam int MODE_ACTIVE_FLAG      = 0;
  localparam int CSEL_CLOCK_POLARITY   = 4;
  localparam int CSEL_DATA_PHASE       = 3;
  localparam int CSEL_SOURCE_HI        = 2;
  localparam int CSEL_SOURCE_LO        = 0;
  localparam int PIN_CLOCK             = 0;
  localparam int PIN_INPUT             = 1;
  localparam int PIN_OUTPUT            = 2;

  // ----------------------------------------------------------------
  // reset values and codes
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_PORT1_DIRECTION = 8'hFF;
  localparam logic [7:0] RST_PORT1_LATCH     = 8'h00;
  localparam logic [7:0] RST_SERIAL_MODE     = 8'h00;
  localparam logic [7:0] RST_CLOCK_SELECT    = 8'h00;
  localparam logic [7:0] RST_SHIFT_REGISTER  = 8'h00;
  localparam logic [7:0] RST_TRANSMIT_BUFFER = 8'h00;
  localparam logic [2:0] CKS_SLAVE           = 3'h7;
  localparam logic [3:0] LAST_EDGE           = 4'hF;

  typedef enum logic [0:0] {
    XFER_IDLE,
    XFER_SHIFT
  } xfer_state_t;

endpackage

// ### hdl/shift_link_if.sv
`timescale 1ns/1ps

// control and tick between the port logic and its clock divider
interface shift_link_if;
  logic       run;
  logic [2:0] cks;
  logic       half_tick;

  modport gen (input run, input cks, output half_tick);
  modport ctl (output run, output cks, input half_tick);
endinterface

// ### hdl/three_wire_serial_port.sv
`timescale 1ns/1ps

// Summary of operation
// - enabled and transmit/receive mode: transmit buffer write starts a transfer
// - one 8-bit shift register serialises out and deserialises in
// - receive-only mode: reading the shift register starts a transfer
// - each received bit is taken from the serial input pin
// - after reset shift register is 00; transmit buffer also resets to 00
// - mode register is byte writable and resets to 00
// - enable 0 stops the port and clears status flag and shift register
// - mode 0 is receive only with output low; mode 1 is full duplex
// - status flag is read only and shows a transfer in progress
// - clock select resets to 00, phase type 1
// - polarity and phase bits pick one of four timing types
// - source codes 0-6 divide pclk by 2..128; code 7 takes external clock
// - direction bit 0 makes output, 1 makes input; resets to FF
// - when disabled no serial traffic and pins are plain port pins
// - status set at start; after eight bits done pulse and status cleared
// - bits move in step with the serial clock, eight per unit

module three_wire_serial_port
  import serial_port_pkg::*;
#(
  parameter int ADDR_W = 18,
  parameter int CNT_W  = 7
) (
  // apb clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // port 1 pins: bit 0 clock, bit 1 serial in, bit 2 serial out
  input  wire logic [7:0]        p1_in,
  output logic      [7:0]        p1_out,
  output logic      [7:0]        p1_oe,
  // completion pulse of an eight bit transfer
  output logic                   transfer_done
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  dir;
    logic [7:0]  latch;
    logic        en;
    logic        trmd;
    logic        lsb;
    logic        ckp;
    logic        dap;
    logic [2:0]  cks;
    logic [7:0]  txbuf;
    logic [7:0]  shreg;
    logic [3:0]  edges;
    logic        sck;
    logic        sout;
    logic        sck_prev;
    xfer_state_t st;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  pin_out;
    logic [7:0]  pin_oe;
    logic        done;
  } port_state_t;

  port_state_t s_ff;
  port_state_t nxt_s;

  shift_link_if link ();

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // outgoing end of the shift register for the chosen bit order
  function automatic logic out_bit(input logic lsb, input logic [7:0] sh);
    out_bit = lsb ? sh[0] : sh[7];
  endfunction

  // shift one bit in at the far end from the outgoing one
  function automatic logic [7:0] shift_in(input logic lsb, input logic [7:0] sh,
                                          input logic si);
    shift_in = lsb ? {si, sh[7:1]} : {sh[6:0], si};
  endfunction

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic [15:0] idx;
  logic        mapped;
  logic        setup;
  logic        access_ok;
  logic        wr;
  logic        rd;
  logic [7:0]  mode_rd;
  logic [7:0]  csel_rd;
  logic [7:0]  rd_byte;

  // index is the word address; low two address bits must be zero
  assign idx = paddr[17:2];
  assign setup = psel && !penable;
  assign access_ok = psel && penable && s_ff.pready && !s_ff.pslverr;
  assign wr = access_ok && pwrite;
  assign rd = access_ok && !pwrite;

  always_comb begin
    mapped = (paddr[1:0] == 2'h0) &&
             (idx == IDX_PORT1_DIRECTION || idx == IDX_SERIAL_MODE ||
              idx == IDX_CLOCK_SELECT || idx == IDX_TRANSMIT_BUFFER ||
              idx == IDX_SHIFT_REGISTER || idx == IDX_PORT1_LATCH);
  end

  // reserved bits read as zero; status flag reflects the engine state
  always_comb begin
    mode_rd = 8'h00;
    mode_rd[MODE_PORT_ENABLE] = s_ff.en;
    mode_rd[MODE_TXRX_SELECT] = s_ff.trmd;
    mode_rd[MODE_BIT_ORDER]   = s_ff.lsb;
    mode_rd[MODE_ACTIVE_FLAG] = (s_ff.st == XFER_SHIFT);
    csel_rd = 8'h00;
    csel_rd[CSEL_CLOCK_POLARITY] = s_ff.ckp;
    csel_rd[CSEL_DATA_PHASE]     = s_ff.dap;
    csel_rd[CSEL_SOURCE_HI:CSEL_SOURCE_LO] = s_ff.cks;
  end

  always_comb begin
    case (idx)
      IDX_PORT1_DIRECTION: rd_byte = s_ff.dir;
      IDX_PORT1_LATCH:     rd_byte = s_ff.latch;
      IDX_SERIAL_MODE:     rd_byte = mode_rd;
      IDX_CLOCK_SELECT:    rd_byte = csel_rd;
      IDX_TRANSMIT_BUFFER: rd_byte = s_ff.txbuf;
      IDX_SHIFT_REGISTER:  rd_byte = s_ff.shreg;
      default:             rd_byte = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // serial clock edges
  // ----------------------------------------------------------------
  logic master;
  logic idle_lvl;
  logic busy;
  logic act_now;
  logic act_prev;
  logic lead;
  logic trail;
  logic sample;
  logic drive;

  assign master   = (s_ff.cks != CKS_SLAVE);
  assign idle_lvl = ~s_ff.ckp;
  assign busy     = (s_ff.st == XFER_SHIFT);
  // slave clock is "active" when away from its idle level
  assign act_now  = p1_in[PIN_CLOCK] ^ idle_lvl;
  assign act_prev = s_ff.sck_prev ^ idle_lvl;

  always_comb begin
    if (master) begin
      lead  = busy && link.half_tick && (s_ff.sck == idle_lvl);
      trail = busy && link.half_tick && (s_ff.sck != idle_lvl);
    end else begin
      lead  = busy && act_now && !act_prev;
      trail = busy && !act_now && act_prev;
    end
  end

  // phase bit picks whether data is sampled on the leading or trailing
  // edge; the opposite edge presents the next bit
  assign sample = s_ff.dap ? lead : trail;
  assign drive  = s_ff.dap ? trail : lead;

  assign link.run = busy && master;
  assign link.cks = s_ff.cks;

  serial_clock_divider #(
    .CNT_W (CNT_W)
  ) u_divider (
    .pclk    (pclk),
    .presetn (presetn),
    .link    (link.gen)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_s = s_ff;
    nxt_s.done = 1'b0;
    nxt_s.sck_prev = p1_in[PIN_CLOCK];

    // no wait state: read data and error are prepared in the setup
    // cycle so every bus output leaves a flip-flop
    nxt_s.pready  = setup;
    nxt_s.pslverr = setup && !mapped;
    nxt_s.prdata  = setup ? {24'h000000, rd_byte} : 32'h00000000;

    // register writes take effect at the completing access edge
    if (wr) begin
      case (idx)
        IDX_PORT1_DIRECTION: nxt_s.dir = pwdata[7:0];
        IDX_PORT1_LATCH:     nxt_s.latch = pwdata[7:0];
        IDX_SERIAL_MODE: begin
          nxt_s.en   = pwdata[MODE_PORT_ENABLE];
          nxt_s.trmd = pwdata[MODE_TXRX_SELECT];
          nxt_s.lsb  = pwdata[MODE_BIT_ORDER];
        end
        IDX_CLOCK_SELECT: begin
          nxt_s.ckp = pwdata[CSEL_CLOCK_POLARITY];
          nxt_s.dap = pwdata[CSEL_DATA_PHASE];
          nxt_s.cks = pwdata[CSEL_SOURCE_HI:CSEL_SOURCE_LO];
        end
        IDX_TRANSMIT_BUFFER: begin
          nxt_s.txbuf = pwdata[7:0];
          // a write during a transfer only updates the buffer
          if (s_ff.en && s_ff.trmd && !busy) begin
            nxt_s.st    = XFER_SHIFT;
            nxt_s.shreg = pwdata[7:0];
            nxt_s.edges = 4'h0;
            nxt_s.sout  = out_bit(s_ff.lsb, pwdata[7:0]);
          end
        end
        default: begin
        end
      endcase
    end

    // receive-only start: the old contents are returned first
    if (rd && idx == IDX_SHIFT_REGISTER && s_ff.en && !s_ff.trmd && !busy) begin
      nxt_s.st    = XFER_SHIFT;
      nxt_s.edges = 4'h0;
    end

    // engine: each clock edge is counted, sixteen make eight bits
    case (s_ff.st)
      XFER_IDLE: begin
        nxt_s.sck = idle_lvl;
      end
      XFER_SHIFT: begin
        if (lead || trail) begin
          if (master) begin
            nxt_s.sck = ~s_ff.sck;
          end
          if (sample) begin
            nxt_s.shreg = shift_in(s_ff.lsb, s_ff.shreg, p1_in[PIN_INPUT]);
          end
          if (drive) begin
            nxt_s.sout = out_bit(s_ff.lsb, sample ? nxt_s.shreg : s_ff.shreg);
          end
          if (s_ff.edges == LAST_EDGE) begin
            // clock parks at its idle level after the eighth bit
            nxt_s.st   = XFER_IDLE;
            nxt_s.done = 1'b1;
          end else begin
            nxt_s.edges = s_ff.edges + 4'h1;
          end
        end
      end
      default: begin
        nxt_s.st = XFER_IDLE;
      end
    endcase

    // disable clears the engine at the same edge as the write, so a
    // stuck slave frame can always be abandoned by software
    if (!nxt_s.en) begin
      nxt_s.st    = XFER_IDLE;
      nxt_s.shreg = RST_SHIFT_REGISTER;
      nxt_s.edges = 4'h0;
      nxt_s.sck   = ~nxt_s.ckp;
      nxt_s.sout  = 1'b0;
      nxt_s.done  = 1'b0;
    end

    // pins: direction gates drivers, serial function muxed when enabled
    nxt_s.pin_oe  = ~nxt_s.dir;
    nxt_s.pin_out = nxt_s.latch;
    if (nxt_s.en) begin
      if (nxt_s.cks != CKS_SLAVE) begin
        nxt_s.pin_out[PIN_CLOCK] = nxt_s.sck;
      end
      nxt_s.pin_out[PIN_OUTPUT] = nxt_s.trmd & nxt_s.sout;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff.dir      <= RST_PORT1_DIRECTION;
      s_ff.latch    <= RST_PORT1_LATCH;
      s_ff.en       <= RST_SERIAL_MODE[MODE_PORT_ENABLE];
      s_ff.trmd     <= RST_SERIAL_MODE[MODE_TXRX_SELECT];
      s_ff.lsb      <= RST_SERIAL_MODE[MODE_BIT_ORDER];
      s_ff.ckp      <= RST_CLOCK_SELECT[CSEL_CLOCK_POLARITY];
      s_ff.dap      <= RST_CLOCK_SELECT[CSEL_DATA_PHASE];
      s_ff.cks      <= RST_CLOCK_SELECT[CSEL_SOURCE_HI:CSEL_SOURCE_LO];
      s_ff.txbuf    <= RST_TRANSMIT_BUFFER;
      s_ff.shreg    <= RST_SHIFT_REGISTER;
      s_ff.edges    <= 4'h0;
      s_ff.sck      <= 1'b1;
      s_ff.sout     <= 1'b0;
      s_ff.sck_prev <= 1'b1;
      s_ff.st       <= XFER_IDLE;
      s_ff.prdata   <= 32'h00000000;
      s_ff.pready   <= 1'b0;
      s_ff.pslverr  <= 1'b0;
      s_ff.pin_out  <= RST_PORT1_LATCH;
      s_ff.pin_oe   <= 8'h00;
      s_ff.done     <= 1'b0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata        = s_ff.prdata;
  assign pready        = s_ff.pready;
  assign pslverr       = s_ff.pslverr;
  assign p1_out        = s_ff.pin_out;
  assign p1_oe         = s_ff.pin_oe;
  assign transfer_done = s_ff.done;

endmodule // three_wire_serial_port

// ### testbench/serial_peer_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// far side peer: eight bit clocked serial slave
// ----------------------------------------------------------------
module serial_peer_model (
  // pins and setup
  input  wire logic       sck,
  input  wire logic       sdo,
  input  wire logic       load,
  input  wire logic       cpol,
  input  wire logic       cpha,
  input  wire logic       lsb,
  input  wire logic [7:0] tx,
  // data toward the port, byte seen
  output logic            sdi,
  output logic [7:0]      rx
);
  logic s;
  int   pc = 0;
  int   rc = 0;

  // s idles high in every type, so leading edge is always its fall
  assign s = sck ^ cpol;
  initial sdi = 1'b0;
  initial rx = 8'h00;

  // past the last bit the line shows the inverse, never a stale copy
  task automatic present();
    if (pc < 8) sdi = lsb ? tx[pc] : tx[7-pc];
    else sdi = ~sdi;
    pc++;
  endtask

  task automatic sample();
    if (rc < 8) rx[lsb ? rc : 7-rc] = sdo;
    rc++;
  endtask

  always @(posedge load) begin
    pc = 0;
    rc = 0;
    sdi = ~sdi;
    if (cpha) present();
  end

  always @(negedge s) if (cpha) sample(); else present();
  always @(posedge s) if (cpha) present(); else sample();
endmodule // serial_peer_model

// ### testbench/serial_port_chk.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// port checker: shadows control registers from committed apb access
// ----------------------------------------------------------------
module serial_port_chk
  import serial_port_pkg::*;
#(
  parameter int ADDR_W = 18,
  parameter int CNT_W  = 7
) (
  // apb
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // pins and completion
  input wire logic [7:0]        p1_in,
  input wire logic [7:0]        p1_out,
  input wire logic [7:0]        p1_oe,
  input wire logic              transfer_done
);
  logic [7:0]  mode_ff;
  logic [7:0]  csel_ff;
  logic        busy_ff;
  logic [15:0] idx;
  logic        acc;
  logic        start;
  logic        mapped;
  logic [10:0] run_cnt;

  // longest frame is sixteen half periods of 64 cycles plus start latency
  localparam int RUN_LIMIT = 1100;

  // committed access, and the accesses that launch a transfer
  assign idx    = paddr[ADDR_W-1:2];
  assign acc    = psel && penable && pready && !pslverr;
  assign mapped = paddr[1:0] == 2'h0 && idx inside {IDX_PORT1_DIRECTION, IDX_PORT1_LATCH,
                  IDX_SERIAL_MODE, IDX_CLOCK_SELECT, IDX_TRANSMIT_BUFFER, IDX_SHIFT_REGISTER};
  assign start  = acc && mode_ff[7] && !busy_ff && (mode_ff[6] ?
                  pwrite && idx == IDX_TRANSMIT_BUFFER : !pwrite && idx == IDX_SHIFT_REGISTER);

  // busy shadow lags a disable by one cycle, so it is only used as a bound
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_ff <= 8'h00;
      csel_ff <= 8'h00;
      busy_ff <= 1'b0;
      run_cnt <= '0;
    end else begin
      // frame age counter, saturating so it never wraps back under the limit
      if (start) run_cnt <= '0;
      else if (busy_ff && run_cnt != '1) run_cnt <= run_cnt + 1'b1;
      if (acc && pwrite && idx == IDX_SERIAL_MODE) mode_ff <= pwdata[7:0];
      if (acc && pwrite && idx == IDX_CLOCK_SELECT) csel_ff <= pwdata[7:0];
      if (start) busy_ff <= 1'b1;
      else if (transfer_done || !mode_ff[7]) busy_ff <= 1'b0;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ready_after_setup: assert property (psel && !penable |=> pready && penable)
    else $error("no ready in access cycle");
  a_ready_in_access: assert property (pready |-> penable && $past(psel && !penable))
    else $error("ready outside access cycle");
  a_unmapped_refused: assert property (psel && penable && pready && !mapped |-> pslverr)
    else $error("unmapped access not refused");
  a_oe_follows_dir: assert property (acc && pwrite && idx == IDX_PORT1_DIRECTION
    |=> p1_oe == ~$past(pwdata[7:0])) else $error("output enable not inverse of direction");
  a_done_bounded: assert property (start |=> !transfer_done [*8])
    else $error("transfer shorter than eight bits");
  a_done_in_time: assert property (busy_ff |-> run_cnt <= RUN_LIMIT)
    else $error("transfer length wrong");
  a_done_single: assert property (transfer_done |-> busy_ff ##1 !transfer_done)
    else $error("done pulse without transfer or too long");
  a_out_low_rx: assert property ((mode_ff[7] && !mode_ff[6]) [*2] |-> !p1_out[2])
    else $error("serial out not low in receive mode");
  a_clock_idle: assert property ((mode_ff[7] && !busy_ff && csel_ff[2:0] != CKS_SLAVE) [*3]
    |-> p1_out[0] == !csel_ff[4]) else $error("idle clock level wrong");
endmodule // serial_port_chk

bind three_wire_serial_port serial_port_chk #(.ADDR_W(ADDR_W), .CNT_W(CNT_W)) chk_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .p1_in(p1_in), .p1_out(p1_out), .p1_oe(p1_oe), .transfer_done(transfer_done));

// ### testbench/tb_top.sv
`timescale 1ns/1ps

module tb_top
  import serial_port_pkg::*;
;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [17:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  p1_in;
  logic [7:0]  p1_out;
  logic [7:0]  p1_oe;
  logic        transfer_done;
  logic        load;
  logic        cpol;
  logic        cpha;
  logic        lsb;
  logic        sdi;
  logic [7:0]  peer_tx;
  logic [7:0]  peer_rx;
  logic [7:0]  pin_rnd;
  logic [7:0]  q;
  logic        e;
  logic        slave;
  logic        ext_sck;
  int          last_rx;
  int          err_count;
  int          comparisons;

  // ----------------------------------------------------------------
  // pins, design and peer
  // ----------------------------------------------------------------
  // undriven pins 2 to 7 float to random levels so stale values never pass; an undriven pin 0 takes ext_sck
  assign p1_in = {pin_rnd[7:3], p1_oe[2] ? p1_out[2] : pin_rnd[2], sdi,
                  p1_oe[0] ? p1_out[0] : ext_sck};
  always #50 pclk = ~pclk;

  three_wire_serial_port #(.ADDR_W(18), .CNT_W(7)) three_wire_serial_port_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .p1_in(p1_in), .p1_out(p1_out), .p1_oe(p1_oe), .transfer_done(transfer_done));
  serial_peer_model serial_peer_model_inst (.sck(p1_in[0]), .sdo(p1_in[2]), .load(load),
    .cpol(cpol), .cpha(cpha), .lsb(lsb), .tx(peer_tx), .sdi(sdi), .rx(peer_rx));

  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one apb transfer; read data and error land in q and e
  task automatic apb(input logic w, input logic [15:0] ix, input logic [7:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {ix, 2'h0};
    pwdata  <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) err_count++;
    q = prdata[7:0];
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic expect_rd(input string name, input logic [15:0] ix, input logic [7:0] exp);
    apb(1'b0, ix, 8'h00);
    check(name, exp, q);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      apb(1'b0, IDX_SERIAL_MODE, 8'h00);
      n++;
    end while (q[0] !== 1'b0 && n < 300);
    check("busy clear", 8'h00, {7'h0, q[0]});
  endtask

  // arm the peer, start a transfer, wait for it and compare what the peer received
  task automatic xfer(input logic full, input logic [7:0] d);
    @(posedge pclk);
    load <= 1'b1;
    @(posedge pclk);
    load <= 1'b0;
    apb(full, full ? IDX_TRANSMIT_BUFFER : IDX_SHIFT_REGISTER, d);
    if (!full) check("shift start", 8'(last_rx), q);
    last_rx = peer_tx;
    expect_rd("busy set", IDX_SERIAL_MODE, {1'b1, full, 1'b0, lsb, 3'h0, 1'b1});
    wait_idle();
    check("peer rx", full ? d : 8'h00, peer_rx);
    // a slave leaves the clock pin to the port latch, which is zero here
    check("clock idle", {7'h0, ~cpol & ~slave}, {7'h0, p1_out[0]});
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge pclk);
    err_count++;
    end_sim();
  end

  initial begin
    void'($urandom(32'h3E6D6ACC));
    {pclk, presetn, psel, penable, pwrite, load, cpol, cpha, lsb} = 9'h000;
    {slave, ext_sck} = 2'h1;
    {paddr, pwdata, peer_tx} = '0;
    {err_count, comparisons, last_rx} = '0;
    pin_rnd = 8'($urandom());
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    expect_rd("direction", IDX_PORT1_DIRECTION, 8'hFF);
    expect_rd("mode", IDX_SERIAL_MODE, 8'h00);
    expect_rd("clock select", IDX_CLOCK_SELECT, 8'h00);
    expect_rd("shift", IDX_SHIFT_REGISTER, 8'h00);
    apb(1'b1, IDX_SERIAL_MODE, 8'h11);
    expect_rd("flag read only", IDX_SERIAL_MODE, 8'h10);
    apb(1'b1, 16'h0123, 8'h55);
    check("unmapped", 8'h01, {7'h0, e});
    apb(1'b1, IDX_PORT1_LATCH, 8'h00);
    apb(1'b1, IDX_PORT1_DIRECTION, 8'hFA);
    @(posedge pclk);
    check("oe", 8'h05, p1_oe);
    $display("test registers done");
    for (int i = 0; i < 8; i++) begin
      peer_tx <= 8'($urandom());
      pin_rnd <= 8'($urandom());
      {cpol, cpha, lsb} <= {2'(i), i[2]};
      apb(1'b1, IDX_SERIAL_MODE, 8'h00);
      apb(1'b1, IDX_CLOCK_SELECT, {3'h0, 2'(i), 3'(i % 4)});
      apb(1'b1, IDX_SERIAL_MODE, {2'h3, 1'b0, i[2], 4'h0});
      xfer(1'b1, 8'($urandom()));
      expect_rd("shift rx", IDX_SHIFT_REGISTER, 8'(last_rx));
    end
    $display("test full duplex done");
    apb(1'b1, IDX_SERIAL_MODE, 8'h00);
    apb(1'b1, IDX_CLOCK_SELECT, 8'h01);
    last_rx = 0;
    {cpol, cpha, lsb} <= 3'h0;
    apb(1'b1, IDX_SERIAL_MODE, 8'h80);
    xfer(1'b0, 8'h00);
    xfer(1'b0, 8'h00);
    $display("test receive only done");
    // slave: the bench drives the clock pin, sixteen edges of four cycles each
    apb(1'b1, IDX_SERIAL_MODE, 8'h00);
    apb(1'b1, IDX_CLOCK_SELECT, {5'h00, CKS_SLAVE});
    apb(1'b1, IDX_PORT1_DIRECTION, 8'hFB);
    apb(1'b1, IDX_SERIAL_MODE, 8'hC0);
    peer_tx <= 8'($urandom());
    slave = 1'b1;
    fork
      xfer(1'b1, 8'($urandom()));
      begin
        repeat (10) @(posedge pclk);
        repeat (16) begin
          repeat (4) @(posedge pclk);
          ext_sck <= ~ext_sck;
        end
      end
    join
    expect_rd("slave rx", IDX_SHIFT_REGISTER, 8'(last_rx));
    slave = 1'b0;
    $display("test slave done");
    apb(1'b1, IDX_SERIAL_MODE, 8'hC0);
    apb(1'b1, IDX_TRANSMIT_BUFFER, 8'($urandom()));
    apb(1'b1, IDX_SERIAL_MODE, 8'h00);
    expect_rd("mode off", IDX_SERIAL_MODE, 8'h00);
    expect_rd("shift off", IDX_SHIFT_REGISTER, 8'h00);
    apb(1'b1, IDX_PORT1_LATCH, 8'h05);
    @(posedge pclk);
    check("port pins", 8'h05, p1_out);
    $display("test disable done");
    end_sim();
  end
endmodule // tb_top
